/* File: rtl/sfw_fifo.sv */
// Parameterised valid/ready FIFO in flip-flops
`timescale 1ns/1ps
module sfw_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  sfw_stream_if.snk s_in,
  sfw_stream_if.src s_out
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] buf_r [DEPTH];
  logic [W-1:0] buf_nxt [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] wp_nxt;
  logic [AW:0] rp_r;
  logic [AW:0] rp_nxt;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // ==========================================================
  // Flags and handshakes
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign s_in.ready = !full;
  assign s_out.valid = !empty;
  assign s_out.data = buf_r[rp_r[AW-1:0]];
  assign push = s_in.valid && !full;
  assign pop = s_out.valid && s_out.ready;

  always_comb
  begin
    buf_nxt = buf_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push)
    begin
      buf_nxt[wp_r[AW-1:0]] = s_in.data;
      wp_nxt = (AW+1)'(wp_r + 1'b1);
    end
    if (pop)
    begin
      rp_nxt = (AW+1)'(rp_r + 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        buf_r[i] <= '0;
      end
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      buf_r <= buf_nxt;
    end
  end

endmodule

/* File: rtl/sfw_pkg.sv */
// Shared constants and types of the serial memory write-enable block
package sfw_pkg;

  // ==========================================================
  // Array geometry
  localparam int ADDR_W = 9;
  localparam int MEM_BYTES = 512;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = ADDR_W + BYTE_W;

  // ==========================================================
  // Command opcodes
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_WRITE_LO = 8'h02;
  localparam logic [7:0] OP_READ_LO = 8'h03;
  localparam logic [7:0] OP_CLR_WE = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_SET_WE = 8'h06;
  localparam logic [7:0] OP_WRITE_HI = 8'h0A;
  localparam logic [7:0] OP_READ_HI = 8'h0B;
  localparam logic [7:0] OP_A8_MASK = 8'hF7;
  localparam int OP_A8_POS = 3;

  // ==========================================================
  // Status byte layout and reset values
  localparam int ST_WEL_POS = 1;
  localparam int ST_BPL_POS = 2;
  localparam int ST_BPH_POS = 3;
  localparam logic WEL_RST = 1'h0;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ==========================================================
  // Pin synchroniser layout and serial counts
  localparam int PIN_CS = 2;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 0;
  localparam logic [2:0] PIN_RST = 3'h4;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPC,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_SRD,
    ST_SWR,
    ST_SKIP
  } sfw_state_t;

endpackage

/* File: rtl/sfw_stream_if.sv */
// Valid/ready stream carrier between the block's own modules
`timescale 1ns/1ps
interface sfw_stream_if #(parameter int W = 17);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/sfw_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sfw_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;

  // ==========================================================
  // Accept a change once stages two and three agree
  for (genvar g = 0; g < W; g++)
  begin : g_filt
    assign lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      lvl_r <= INIT;
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;

endmodule

/* File: rtl/sfw_top.sv */
// Serial memory command interpreter with write-enable latch and status byte
`timescale 1ns/1ps

module sfw_top #(
  parameter int ADDR_W = sfw_pkg::ADDR_W,
  parameter int MEM_BYTES = sfw_pkg::MEM_BYTES,
  parameter int DEPTH = sfw_pkg::FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  output logic [7:0] o_status
);

  localparam int FW = ADDR_W + sfw_pkg::BYTE_W;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] pins_f;
  logic cs_n_f;
  logic sck_f;
  logic si_f;

  sfw_sync #(
    .W(3),
    .INIT(sfw_pkg::PIN_RST)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async({i_cs_n, i_sck, i_si}),
    .o_level(pins_f)
  );

  assign cs_n_f = pins_f[sfw_pkg::PIN_CS];
  assign sck_f = pins_f[sfw_pkg::PIN_SCK];
  assign si_f = pins_f[sfw_pkg::PIN_SI];

  // ==========================================================
  // State
  sfw_pkg::sfw_state_t st_r;
  sfw_pkg::sfw_state_t st_nxt;
  logic sck_d_r;
  logic cs_d_r;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic [7:0] shin_r;
  logic [7:0] shin_nxt;
  logic [7:0] opc_r;
  logic [7:0] opc_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic write_enable_latch_r;
  logic write_enable_latch_nxt;
  logic block_protect_low_r;
  logic block_protect_low_nxt;
  logic block_protect_high_r;
  logic block_protect_high_nxt;
  logic wrote_r;
  logic wrote_nxt;
  logic [7:0] so_sh_r;
  logic [7:0] so_sh_nxt;
  logic so_r;
  logic so_nxt;
  logic so_oe_n_r;
  logic so_oe_n_nxt;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic pend_v_r;
  logic pend_v_nxt;
  logic [FW-1:0] pend_d_r;
  logic [FW-1:0] pend_d_nxt;
  logic [7:0] mem_r [MEM_BYTES];
  logic [7:0] mem_nxt [MEM_BYTES];

  // ==========================================================
  // Edge detection and byte assembly
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic active;
  logic [7:0] byte_in;
  logic byte_done;
  logic out_phase;
  logic fetch;
  logic [7:0] out_byte;

  assign sck_rise = sck_f && !sck_d_r;
  assign sck_fall = !sck_f && sck_d_r;
  assign cs_fall = !cs_n_f && cs_d_r;
  assign cs_rise = cs_n_f && !cs_d_r;
  assign active = !cs_n_f && !cs_d_r && (st_r != sfw_pkg::ST_IDLE);
  assign byte_in = {shin_r[6:0], si_f};
  assign byte_done = active && sck_rise && (bit_r == sfw_pkg::BIT_LAST);
  assign out_phase = (st_r == sfw_pkg::ST_RDATA) || (st_r == sfw_pkg::ST_SRD);
  assign fetch = active && sck_fall && (bit_r == sfw_pkg::BIT_FIRST) && (st_r == sfw_pkg::ST_RDATA);
  assign out_byte = (st_r == sfw_pkg::ST_SRD) ? status_r : mem_r[addr_r];

  // ==========================================================
  // Write path through the FIFO
  sfw_stream_if #(.W(FW)) push_if ();
  sfw_stream_if #(.W(FW)) pop_if ();

  sfw_fifo #(
    .W(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .s_in(push_if),
    .s_out(pop_if)
  );

  assign push_if.valid = pend_v_r;
  assign push_if.data = pend_d_r;
  assign pop_if.ready = !fetch;

  // ==========================================================
  // Array update from the FIFO
  always_comb
  begin
    mem_nxt = mem_r;
    if (pop_if.valid && pop_if.ready)
    begin
      mem_nxt[pop_if.data[FW-1:sfw_pkg::BYTE_W]] = pop_if.data[sfw_pkg::BYTE_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < MEM_BYTES; i++)
      begin
        mem_r[i] <= 8'h00;
      end
    end
    else
    begin
      mem_r <= mem_nxt;
    end
  end

  // ==========================================================
  // Command interpreter
  always_comb
  begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    shin_nxt = shin_r;
    opc_nxt = opc_r;
    addr_nxt = addr_r;
    write_enable_latch_nxt = write_enable_latch_r;
    block_protect_low_nxt = block_protect_low_r;
    block_protect_high_nxt = block_protect_high_r;
    wrote_nxt = wrote_r;
    so_sh_nxt = so_sh_r;
    so_nxt = so_r;
    so_oe_n_nxt = so_oe_n_r;
    pend_v_nxt = pend_v_r;
    pend_d_nxt = pend_d_r;
    if (pend_v_r && push_if.ready)
    begin
      pend_v_nxt = 1'b0;
    end
    if (cs_fall)
    begin
      st_nxt = sfw_pkg::ST_OPC;
      bit_nxt = sfw_pkg::BIT_FIRST;
      opc_nxt = sfw_pkg::OP_NONE;
      wrote_nxt = 1'b0;
      so_oe_n_nxt = 1'b1;
      so_nxt = 1'b0;
    end
    else if (cs_rise)
    begin
      st_nxt = sfw_pkg::ST_IDLE;
      so_oe_n_nxt = 1'b1;
      so_nxt = 1'b0;
      if (opc_r == sfw_pkg::OP_SET_WE)
      begin
        write_enable_latch_nxt = 1'b1;
      end
      else if (opc_r == sfw_pkg::OP_CLR_WE)
      begin
        write_enable_latch_nxt = 1'b0;
      end
      else if (wrote_r && (opc_r != sfw_pkg::OP_WRITE_HI))
      begin
        write_enable_latch_nxt = 1'b0;
      end
    end
    else if (active)
    begin
      if (sck_rise)
      begin
        shin_nxt = byte_in;
        bit_nxt = 3'(bit_r + 1'b1);
      end
      if (byte_done)
      begin
        unique case (st_r)
          sfw_pkg::ST_OPC:
          begin
            opc_nxt = byte_in;
            addr_nxt[ADDR_W-1] = byte_in[sfw_pkg::OP_A8_POS];
            case (byte_in)
              sfw_pkg::OP_WRITE_LO, sfw_pkg::OP_WRITE_HI, sfw_pkg::OP_READ_LO, sfw_pkg::OP_READ_HI:
                st_nxt = sfw_pkg::ST_ADDR;
              sfw_pkg::OP_STAT_RD:
                st_nxt = sfw_pkg::ST_SRD;
              sfw_pkg::OP_STAT_WR:
                st_nxt = sfw_pkg::ST_SWR;
              default:
                st_nxt = sfw_pkg::ST_SKIP;
            endcase
          end
          sfw_pkg::ST_ADDR:
          begin
            addr_nxt[ADDR_W-2:0] = byte_in;
            if ((opc_r & sfw_pkg::OP_A8_MASK) == sfw_pkg::OP_WRITE_LO)
            begin
              st_nxt = sfw_pkg::ST_WDATA;
            end
            else
            begin
              st_nxt = sfw_pkg::ST_RDATA;
            end
          end
          sfw_pkg::ST_WDATA:
          begin
            if (write_enable_latch_r)
            begin
              pend_v_nxt = 1'b1;
              pend_d_nxt = {addr_r, byte_in};
              wrote_nxt = 1'b1;
              addr_nxt = ADDR_W'(addr_r + 1'b1);
            end
          end
          sfw_pkg::ST_SWR:
          begin
            st_nxt = sfw_pkg::ST_SKIP;
            if (write_enable_latch_r)
            begin
              block_protect_low_nxt = byte_in[sfw_pkg::ST_BPL_POS];
              block_protect_high_nxt = byte_in[sfw_pkg::ST_BPH_POS];
              wrote_nxt = 1'b1;
            end
          end
          sfw_pkg::ST_RDATA, sfw_pkg::ST_SRD, sfw_pkg::ST_SKIP, sfw_pkg::ST_IDLE:
          begin
            st_nxt = st_r;
          end
        endcase
      end
      if (sck_fall && out_phase)
      begin
        so_oe_n_nxt = 1'b0;
        if (bit_r == sfw_pkg::BIT_FIRST)
        begin
          so_nxt = out_byte[7];
          so_sh_nxt = {out_byte[6:0], 1'b0};
        end
        else
        begin
          so_nxt = so_sh_r[7];
          so_sh_nxt = {so_sh_r[6:0], 1'b0};
        end
      end
      if (fetch)
      begin
        addr_nxt = ADDR_W'(addr_r + 1'b1);
      end
    end
  end

  // ==========================================================
  // Status byte image
  always_comb
  begin
    status_nxt = sfw_pkg::STATUS_RST;
    status_nxt[sfw_pkg::ST_WEL_POS] = write_enable_latch_nxt;
    status_nxt[sfw_pkg::ST_BPL_POS] = block_protect_low_nxt;
    status_nxt[sfw_pkg::ST_BPH_POS] = block_protect_high_nxt;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_r <= sfw_pkg::ST_IDLE;
      sck_d_r <= sfw_pkg::PIN_RST[sfw_pkg::PIN_SCK];
      cs_d_r <= sfw_pkg::PIN_RST[sfw_pkg::PIN_CS];
      bit_r <= sfw_pkg::BIT_FIRST;
      shin_r <= 8'h00;
      opc_r <= sfw_pkg::OP_NONE;
      addr_r <= '0;
      write_enable_latch_r <= sfw_pkg::WEL_RST;
      block_protect_low_r <= sfw_pkg::BP_RST[0];
      block_protect_high_r <= sfw_pkg::BP_RST[1];
      wrote_r <= 1'b0;
      so_sh_r <= 8'h00;
      so_r <= 1'b0;
      so_oe_n_r <= 1'b1;
      status_r <= sfw_pkg::STATUS_RST;
      pend_v_r <= 1'b0;
      pend_d_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      sck_d_r <= sck_f;
      cs_d_r <= cs_n_f;
      bit_r <= bit_nxt;
      shin_r <= shin_nxt;
      opc_r <= opc_nxt;
      addr_r <= addr_nxt;
      write_enable_latch_r <= write_enable_latch_nxt;
      block_protect_low_r <= block_protect_low_nxt;
      block_protect_high_r <= block_protect_high_nxt;
      wrote_r <= wrote_nxt;
      so_sh_r <= so_sh_nxt;
      so_r <= so_nxt;
      so_oe_n_r <= so_oe_n_nxt;
      status_r <= status_nxt;
      pend_v_r <= pend_v_nxt;
      pend_d_r <= pend_d_nxt;
    end
  end

  assign o_so = so_r;
  assign o_so_oe_n = so_oe_n_r;
  assign o_status = status_r;

endmodule

/* File: verif/sfw_host_model.sv */
// Behavioural serial host framing commands in mode 0
`timescale 1ns/1ps
module sfw_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so
);
  typedef logic [7:0] sfw_byte_q_t[$];
  logic lclk;
  initial
  begin
    lclk = 1'b0;
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  always #62.5 lclk = ~lclk;
  // ==========================================================
  // Data line toggles while deselected
  always @(posedge lclk)
    if (o_cs_n)
      o_si <= ~o_si;
  // ==========================================================
  // One frame, read bytes sampled before each clock fall
  task automatic frame(input sfw_byte_q_t tx, output sfw_byte_q_t rx);
    logic [7:0] b;
    rx = {};
    @(negedge lclk);
    o_cs_n <= 1'b0;
    foreach (tx[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        o_si <= tx[i][k];
        @(posedge lclk);
        o_sck <= 1'b1;
        @(negedge lclk);
        b[k] = i_so;
        o_sck <= 1'b0;
      end
      rx.push_back(b);
    end
    @(negedge lclk);
    o_cs_n <= 1'b1;
    repeat (3) @(negedge lclk);
  endtask
endmodule

/* File: verif/sfw_top_checker.sv */
// Pin-level assertions for the write-enable block
`timescale 1ns/1ps
module sfw_top_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic o_so,
  input wire logic o_so_oe_n,
  input wire logic [7:0] o_status
);
  // ==========================================================
  // Opcode capture
  logic [2:0] p1_r;
  logic [2:0] p2_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] op_r;
  logic [7:0] op_nxt;
  always_comb
  begin
    cnt_nxt = p2_r[2] ? 4'h0 : cnt_r;
    sh_nxt = sh_r;
    op_nxt = (p2_r[2] && !p1_r[2]) ? 8'h00 : op_r;
    if (!p2_r[2] && p1_r[1] && !p2_r[1] && cnt_r < 4'h8)
    begin
      sh_nxt = {sh_r[6:0], p1_r[0]};
      cnt_nxt = cnt_r + 4'h1;
      op_nxt = (cnt_r == 4'h7) ? sh_nxt : op_r;
    end
  end
  always_ff @(posedge i_ref_clk)
  begin
    p1_r <= i_rst ? 3'h4 : {i_cs_n, i_sck, i_si};
    p2_r <= i_rst ? 3'h4 : p1_r;
    cnt_r <= i_rst ? 4'h0 : cnt_nxt;
    sh_r <= sh_nxt;
    op_r <= i_rst ? 8'h00 : op_nxt;
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Assertions
  rsvd_zero_a:
    assert property (o_status[0] == 1'b0 && o_status[7:4] == 4'h0) else $error("reserved bit set");
  rst_status_a:
    assert property (disable iff (1'b0) i_rst |=> o_status == 8'h00) else $error("status not reset");
  set_latch_a:
    assert property ($rose(i_cs_n) && op_r == 8'h06 |-> ##[1:12] o_status[1]) else $error("latch not set");
  clr_latch_a:
    assert property ($rose(i_cs_n) && op_r == 8'h04 |-> ##[1:12] !o_status[1]) else $error("latch not cleared");
  rise_src_a:
    assert property ($rose(o_status[1]) |-> op_r == 8'h06) else $error("latch set wrongly");
  fall_src_a:
    assert property ($fell(o_status[1]) |-> op_r inside {8'h01, 8'h02, 8'h04}) else $error("latch cleared wrongly");
  bp_src_a:
    assert property ($changed(o_status[3:2]) |-> op_r == 8'h01 && $past(o_status[1]))
      else $error("protect bits wrong");
  so_drive_a:
    assert property ($rose(o_so) |-> !o_so_oe_n) else $error("data driven while output disabled");
  oe_idle_a:
    assert property (i_cs_n [*8] |-> o_so_oe_n && !o_so) else $error("output enabled while deselected");
  upper_keep_a:
    assert property ($rose(i_cs_n) && op_r == 8'h0A && o_status[1] |=> o_status[1] [*8]) else $error("latch lost");
  cover property ($rose(o_status[1]));
  cover property ($rose(i_cs_n) && op_r == 8'h0A && o_status[1]);
  cover property ($changed(o_status[3:2]));
  cover property ($fell(o_so_oe_n) ##[1:20] o_so);
endmodule
bind sfw_top sfw_top_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n),
  .i_si(i_si), .o_so(o_so), .o_so_oe_n(o_so_oe_n), .o_status(o_status)
);

/* File: verif/tb_sfw_top.sv */
// Self-checking bench for the write-enable block
`timescale 1ns/1ps
module tb_sfw_top;
  typedef logic [7:0] sfw_byte_q_t[$];
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe_n;
  logic [7:0] status;
  logic [7:0] ops[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0B};
  int err_count = 0;
  int check_count = 0;
  int mem_m[512];
  int wel_m = 0;
  int bp_m = 0;
  always #5 ref_clk = ~ref_clk;
  sfw_top u_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so),
    .o_so_oe_n(so_oe_n), .o_status(status));
  sfw_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));
  // ==========================================================
  // Checking and closing
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // One command frame against the model
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input int n);
    sfw_byte_q_t tx;
    sfw_byte_q_t rx;
    int a;
    int hit;
    a = op[3] * 256 + b1;
    hit = 0;
    tx.push_back(op);
    if (n > 1)
      tx.push_back(b1);
    for (int i = 2; i < n; i++)
      tx.push_back(8'($urandom));
    u_host.frame(tx, rx);
    if (op == 8'h01 && n > 1 && wel_m == 1)
    begin
      bp_m = b1[3:2];
      hit = 1;
    end
    for (int i = 1; i < n; i++)
    begin
      if (op == 8'h05)
        check("status_rd", 8'(wel_m * 2 + bp_m * 4), rx[i]);
      if (i > 1 && (op == 8'h03 || op == 8'h0B))
        check("rd_data", 8'(mem_m[a]), rx[i]);
      if (i > 1 && (op == 8'h02 || op == 8'h0A) && wel_m == 1)
      begin
        mem_m[a] = tx[i];
        hit = 1;
      end
      if (i > 1)
        a = (a + 1) % 512;
    end
    if (op == 8'h06)
      wel_m = 1;
    if (op == 8'h04 || (hit == 1 && op != 8'h0A))
      wel_m = 0;
    check("status", 8'(wel_m * 2 + bp_m * 4), status);
    check("so_oe_n", 8'h01, 8'(so_oe_n));
    check("so_idle", 8'h00, 8'(so));
  endtask
  task automatic reset_dut();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    mem_m = '{default: 0};
    wel_m = 0;
    bp_m = 0;
    check("status_rst", 8'h00, status);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h40D7));
    reset_dut();
    run(8'h05, 8'h00, 3);
    run(8'h02, 8'h10, 6);
    run(8'h06, 8'h00, 1);
    run(8'h02, 8'h10, 6);
    run(8'h02, 8'h20, 4);
    run(8'h03, 8'h0E, 10);
    run(8'h06, 8'h00, 1);
    run(8'hC2, 8'hF8, 4);
    run(8'h0A, 8'hF8, 22);
    run(8'h01, 8'hFF, 2);
    run(8'h06, 8'h00, 1);
    run(8'h01, 8'h06, 2);
    run(8'h06, 8'h00, 1);
    run(8'h02, 8'hFE, 5);
    run(8'h06, 8'h00, 1);
    run(8'h0A, 8'h40, 3);
    run(8'h04, 8'h00, 1);
    run(8'h0A, 8'h41, 3);
    run(8'h0B, 8'hF8, 24);
    run(8'h03, 8'hFC, 6);
    for (int j = 0; j < 40; j++)
      run(ops[$urandom % 8], 8'($urandom), 1 + $urandom % 6);
    run(8'h06, 8'h00, 1);
    reset_dut();
    run(8'h0B, 8'hF8, 6);
    end_sim();
  end
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end
endmodule
